// file: rtl/pit_pkg.sv
// How it works
// - Current and voltage samples are checked for peaks in parallel, each sample.
// - Voltage peak sets its flag; the request line goes low if enabled.
// - Current peak sets its flag with the same enable gating.
// - Thresholds meet the top byte of the doubled absolute sample per channel.
// - Detection when threshold is below that top byte; zero catches any nonzero top byte.
// - Two 24-bit peak records grow when a larger absolute sample arrives.
// - Voltage record holds twice the channel 2 peak; current record unscaled.
// - Reading a peak clear alias returns the record, then zeroes it.
// - Events always set flags; enables only gate the request line.
// - Reading address 0ch returns the flags and clears them.
// - Events arriving during the clearing read are kept and reassert the line.
// - Clearing read releases the request line after the command byte.
// - Line stays high until the flag word ends, then shows pending events.
// - Mode bit 5 arms; next channel 2 zero crossing routes the sensor.
// - Sensor code is loaded into the temperature register 24 cycles later.
// - Finished conversion pulls the request line low if enable bit 5 is set.
// - Temperature result is two's complement, one count per degree, uncalibrated.
// - Modulator clock is one quarter of the input clock.
// - Zero cross indication rises on positive crossings, falls on negative ones.
// - Clearing read clears only the flags it returned; events that arrive during it stay set and can drive the request line.
package pit_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 24;
  localparam logic [5:0] MODE_ADDR       = 6'h09;
  localparam logic [5:0] IRQ_EN_ADDR     = 6'h0a;
  localparam logic [5:0] FLAGS_ADDR      = 6'h0b;
  localparam logic [5:0] FLAGS_RC_ADDR   = 6'h0c;
  localparam logic [5:0] I_THR_ADDR      = 6'h1a;
  localparam logic [5:0] V_THR_ADDR      = 6'h1b;
  localparam logic [5:0] I_PEAK_ADDR     = 6'h22;
  localparam logic [5:0] I_PEAK_RC_ADDR  = 6'h23;
  localparam logic [5:0] V_PEAK_ADDR     = 6'h24;
  localparam logic [5:0] V_PEAK_RC_ADDR  = 6'h25;
  localparam logic [5:0] TEMP_ADDR       = 6'h26;

  // ****************************************************************
  // Fields, reset values and timing
  // ****************************************************************
  localparam int unsigned  MODE_TEMP_BIT  = 5;
  localparam int unsigned  TEMP_FLAG_BIT  = 5;
  localparam int unsigned  V_PEAK_FLAG    = 8;
  localparam int unsigned  I_PEAK_FLAG    = 9;
  localparam logic [15:0]  MODE_RST       = 16'h0000;
  localparam logic [15:0]  IRQ_EN_RST     = 16'h0000;
  localparam logic [7:0]   THR_RST        = 8'hff;
  localparam int unsigned  TEMP_DELAY_CYC = 24;
  localparam int unsigned  MOD_DIV        = 4;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic       rsvd;
    logic [5:0] addr;
  } pit_cmd_s;

  typedef enum logic [2:0] {
    T_IDLE  = 3'b001,
    T_ARMED = 3'b010,
    T_CONV  = 3'b100
  } pit_temp_e;

  // Number of data bytes that follow the command byte.
  function automatic logic [1:0] pit_bytes(input logic [5:0] addr);
    case (addr)
      MODE_ADDR, IRQ_EN_ADDR, FLAGS_ADDR, FLAGS_RC_ADDR: pit_bytes = 2'd2;
      I_PEAK_ADDR, I_PEAK_RC_ADDR, V_PEAK_ADDR, V_PEAK_RC_ADDR: pit_bytes = 2'd3;
      default: pit_bytes = 2'd1;
    endcase
  endfunction : pit_bytes

endpackage : pit_pkg

// file: rtl/pit_monitor.sv
`timescale 1ns/100ps
module pit_monitor
  import pit_pkg::*;
(
  // System
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Serial port
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  // Sample streams
  input  wire logic [23:0] ch1_sample_i,
  input  wire logic        ch1_valid_i,
  input  wire logic [23:0] ch2_sample_i,
  input  wire logic        ch2_valid_i,
  input  wire logic [7:0]  temp_code_i,
  // Status pins
  output logic             irq_n_o,
  output logic             irq_oe_o,
  output logic             zero_cross_o,
  output logic             temp_route_o,
  output logic             mod_clk_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [23:0] abs24(input logic [23:0] s);
    abs24 = s[23] ? 24'(-s) : s;
  endfunction : abs24

  // Doubles an absolute value, saturating at the top of 24 bits.
  function automatic logic [23:0] dbl_sat(input logic [23:0] a);
    dbl_sat = a[23] ? 24'hffffff : {a[22:0], 1'b0};
  endfunction : dbl_sat

  // ****************************************************************
  // Link side: command and data shift on the serial clock
  // ****************************************************************
  logic       frame_rst_n;
  logic [5:0] bit_cnt_reg, bit_cnt_next;
  logic [23:0] shift_reg, shift_next;
  pit_cmd_s   cmd_reg, cmd_next;
  logic       cmd_tgl_reg, cmd_tgl_next;
  logic       done_tgl_reg, done_tgl_next;
  logic [23:0] wdata_reg, wdata_next;
  logic [5:0] last_bit;
  logic [23:0] out_reg, out_next;
  logic [23:0] rd_word_reg, rd_word_next;

  assign frame_rst_n = rst_n_i & ~cs_n_i;
  assign last_bit    = 6'({1'b0, pit_bytes(cmd_reg.addr), 3'b000}) + 6'd7;

  always_comb begin
    bit_cnt_next  = (bit_cnt_reg == 6'd32) ? bit_cnt_reg : bit_cnt_reg + 6'd1;
    shift_next    = {shift_reg[22:0], mosi_i};
    cmd_next      = cmd_reg;
    cmd_tgl_next  = cmd_tgl_reg;
    done_tgl_next = done_tgl_reg;
    wdata_next    = wdata_reg;
    if (bit_cnt_reg == 6'd7) begin
      cmd_next     = pit_cmd_s'({shift_reg[6:0], mosi_i});
      cmd_tgl_next = ~cmd_tgl_reg;
    end else if (bit_cnt_reg > 6'd7 && bit_cnt_reg == last_bit) begin
      done_tgl_next = ~done_tgl_reg;
      if (cmd_reg.wr) begin
        wdata_next = {shift_reg[22:0], mosi_i};
      end
    end
  end

  always_ff @(posedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_reg <= 6'd0;
      shift_reg   <= 24'h000000;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      shift_reg   <= shift_next;
    end
  end

  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_reg      <= '0;
      cmd_tgl_reg  <= 1'b0;
      done_tgl_reg <= 1'b0;
      wdata_reg    <= 24'h000000;
    end else begin
      cmd_reg      <= cmd_next;
      cmd_tgl_reg  <= cmd_tgl_next;
      done_tgl_reg <= done_tgl_next;
      wdata_reg    <= wdata_next;
    end
  end

  // Read data leaves MSB first on falling edges; the word was aligned at capture.
  always_comb begin
    out_next = out_reg;
    if (bit_cnt_reg == 6'd8) begin
      out_next = rd_word_reg;
    end else if (bit_cnt_reg > 6'd8) begin
      out_next = {out_reg[22:0], 1'b0};
    end
  end

  always_ff @(negedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      out_reg <= 24'h000000;
    end else begin
      out_reg <= out_next;
    end
  end

  assign miso_o    = out_reg[23];
  assign miso_oe_o = ~cs_n_i & ~cmd_reg.wr & (bit_cnt_reg >= 6'd8);

  // ****************************************************************
  // Crossing of link events into the system clock
  // ****************************************************************
  logic [2:0] cmd_sync_reg, done_sync_reg;
  logic       cmd_ev, done_ev;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_sync_reg  <= 3'b000;
      done_sync_reg <= 3'b000;
    end else begin
      cmd_sync_reg  <= {cmd_sync_reg[1:0], cmd_tgl_reg};
      done_sync_reg <= {done_sync_reg[1:0], done_tgl_reg};
    end
  end

  assign cmd_ev  = cmd_sync_reg[2] ^ cmd_sync_reg[1];
  assign done_ev = done_sync_reg[2] ^ done_sync_reg[1];

  // ****************************************************************
  // Registers, peaks, flags and request line
  // ****************************************************************
  pit_cmd_s    cur_reg, cur_next;
  logic [15:0] mode_reg, mode_next;
  logic [15:0] irq_en_reg, irq_en_next;
  logic [15:0] flags_reg, flags_next;
  logic [15:0] snap_reg, snap_next;
  logic        hold_reg, hold_next;
  logic        irq_n_reg, irq_n_next;
  logic [7:0]  i_thr_reg, i_thr_next;
  logic [7:0]  v_thr_reg, v_thr_next;
  logic [23:0] i_peak_reg, i_peak_next;
  logic [23:0] v_peak_reg, v_peak_next;
  logic [7:0]  temp_reg, temp_next;
  logic        zx_reg, zx_next;
  logic [1:0]  div_reg, div_next;
  pit_temp_e   t_state_reg, t_state_next;
  logic [4:0]  t_cnt_reg, t_cnt_next;
  logic [23:0] ch1_abs, ch1_dbl, ch2_dbl, rd_val;
  logic [15:0] set_vec;
  logic        i_pk_hit, v_pk_hit, zx_edge, temp_done, rd_end, wr_end;

  assign ch1_abs  = abs24(ch1_sample_i);
  assign ch1_dbl  = dbl_sat(ch1_abs);
  assign ch2_dbl  = dbl_sat(abs24(ch2_sample_i));
  assign i_pk_hit = ch1_valid_i && (i_thr_reg < ch1_dbl[23:16]);
  assign v_pk_hit = ch2_valid_i && (v_thr_reg < ch2_dbl[23:16]);
  assign zx_edge  = ch2_valid_i && (zx_reg != ~ch2_sample_i[23]);
  assign temp_done = (t_state_reg == T_CONV) && (t_cnt_reg == 5'(TEMP_DELAY_CYC - 1));
  assign rd_end   = done_ev && !cur_reg.wr;
  assign wr_end   = done_ev && cur_reg.wr;

  always_comb begin
    set_vec = 16'h0000;
    set_vec[V_PEAK_FLAG]   = v_pk_hit;
    set_vec[I_PEAK_FLAG]   = i_pk_hit;
    set_vec[TEMP_FLAG_BIT] = temp_done;
  end

  always_comb begin
    case (cur_next.addr)
      MODE_ADDR:                     rd_val = {8'h00, mode_reg};
      IRQ_EN_ADDR:                   rd_val = {8'h00, irq_en_reg};
      FLAGS_ADDR, FLAGS_RC_ADDR:     rd_val = {8'h00, flags_reg};
      I_THR_ADDR:                    rd_val = {16'h0000, i_thr_reg};
      V_THR_ADDR:                    rd_val = {16'h0000, v_thr_reg};
      I_PEAK_ADDR, I_PEAK_RC_ADDR:   rd_val = i_peak_reg;
      V_PEAK_ADDR, V_PEAK_RC_ADDR:   rd_val = v_peak_reg;
      TEMP_ADDR:                     rd_val = {16'h0000, temp_reg};
      default:                       rd_val = 24'h000000;
    endcase
  end

  always_comb begin
    cur_next     = cmd_ev ? cmd_reg : cur_reg;
    rd_word_next = rd_word_reg;
    snap_next    = snap_reg;
    hold_next    = hold_reg;
    mode_next    = mode_reg;
    irq_en_next  = irq_en_reg;
    i_thr_next   = i_thr_reg;
    v_thr_next   = v_thr_reg;
    if (cmd_ev && !cmd_reg.wr) begin
      case (pit_bytes(cmd_reg.addr))
        2'd1:    rd_word_next = {rd_val[7:0], 16'h0000};
        2'd2:    rd_word_next = {rd_val[15:0], 8'h00};
        default: rd_word_next = rd_val;
      endcase
      if (cmd_reg.addr == FLAGS_RC_ADDR) begin
        snap_next = flags_reg;
        hold_next = 1'b1;
      end
    end
    if (rd_end && cur_reg.addr == FLAGS_RC_ADDR) begin
      hold_next = 1'b0;
    end
    if (wr_end) begin
      case (cur_reg.addr)
        MODE_ADDR:   mode_next   = wdata_reg[15:0];
        IRQ_EN_ADDR: irq_en_next = wdata_reg[15:0];
        I_THR_ADDR:  i_thr_next  = wdata_reg[7:0];
        V_THR_ADDR:  v_thr_next  = wdata_reg[7:0];
        default:     mode_next   = mode_reg;
      endcase
    end else if (temp_done) begin
      mode_next[MODE_TEMP_BIT] = 1'b0;
    end
    // Only flags that were shown to the host are cleared; new events win.
    flags_next = flags_reg | set_vec;
    if (rd_end && cur_reg.addr == FLAGS_RC_ADDR) begin
      flags_next = (flags_reg & ~snap_reg) | set_vec;
    end
    irq_n_next = ~((|(flags_next & irq_en_next)) & ~hold_next);
  end

  always_comb begin
    i_peak_next = i_peak_reg;
    v_peak_next = v_peak_reg;
    if (rd_end && cur_reg.addr == I_PEAK_RC_ADDR) begin
      i_peak_next = 24'h000000;
    end
    if (rd_end && cur_reg.addr == V_PEAK_RC_ADDR) begin
      v_peak_next = 24'h000000;
    end
    if (ch1_valid_i && ch1_abs > i_peak_next) begin
      i_peak_next = ch1_abs;
    end
    if (ch2_valid_i && ch2_dbl > v_peak_next) begin
      v_peak_next = ch2_dbl;
    end
  end

  // ****************************************************************
  // Temperature sequencing, zero cross and modulator clock
  // ****************************************************************
  always_comb begin
    t_state_next = t_state_reg;
    t_cnt_next   = t_cnt_reg;
    temp_next    = temp_reg;
    zx_next      = ch2_valid_i ? ~ch2_sample_i[23] : zx_reg;
    div_next     = 2'(div_reg + 2'd1);
    case (t_state_reg)
      T_IDLE: begin
        if (mode_reg[MODE_TEMP_BIT]) begin
          t_state_next = T_ARMED;
        end
      end
      T_ARMED: begin
        if (zx_edge) begin
          t_state_next = T_CONV;
          t_cnt_next   = 5'd0;
        end
      end
      T_CONV: begin
        t_cnt_next = t_cnt_reg + 5'd1;
        if (temp_done) begin
          temp_next    = temp_code_i;
          t_state_next = T_IDLE;
        end
      end
      default: t_state_next = T_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_reg     <= '0;
      rd_word_reg <= 24'h000000;
      snap_reg    <= 16'h0000;
      hold_reg    <= 1'b0;
      irq_n_reg   <= 1'b1;
      mode_reg    <= MODE_RST;
      irq_en_reg  <= IRQ_EN_RST;
      flags_reg   <= 16'h0000;
      i_thr_reg   <= THR_RST;
      v_thr_reg   <= THR_RST;
      i_peak_reg  <= 24'h000000;
      v_peak_reg  <= 24'h000000;
      temp_reg    <= 8'h00;
      zx_reg      <= 1'b0;
      div_reg     <= 2'd0;
      t_state_reg <= T_IDLE;
      t_cnt_reg   <= 5'd0;
    end else begin
      cur_reg     <= cur_next;
      rd_word_reg <= rd_word_next;
      snap_reg    <= snap_next;
      hold_reg    <= hold_next;
      irq_n_reg   <= irq_n_next;
      mode_reg    <= mode_next;
      irq_en_reg  <= irq_en_next;
      flags_reg   <= flags_next;
      i_thr_reg   <= i_thr_next;
      v_thr_reg   <= v_thr_next;
      i_peak_reg  <= i_peak_next;
      v_peak_reg  <= v_peak_next;
      temp_reg    <= temp_next;
      zx_reg      <= zx_next;
      div_reg     <= div_next;
      t_state_reg <= t_state_next;
      t_cnt_reg   <= t_cnt_next;
    end
  end

  assign irq_n_o      = irq_n_reg;
  assign irq_oe_o     = ~irq_n_reg;
  assign zero_cross_o = zx_reg;
  assign temp_route_o = (t_state_reg == T_CONV);
  assign mod_clk_o    = div_reg[1];

  // Length of the current run of the routing output, read only by the timing check.
  logic [4:0] route_len_reg, route_len_next;

  always_comb begin
    route_len_next = temp_route_o ? route_len_reg + 5'd1 : 5'd0;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      route_len_reg <= 5'd0;
    end else begin
      route_len_reg <= route_len_next;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_irq_hold_high: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hold_reg |-> irq_n_o) else $error("request line low during clearing read");
  a_irq_pending_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!hold_reg && |(flags_reg & irq_en_reg)) |-> !irq_n_o)
    else $error("enabled flag set but request line high");
  a_v_peak_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ch2_valid_i && v_thr_reg < ch2_dbl[23:16]) |=> flags_reg[V_PEAK_FLAG])
    else $error("voltage peak flag not set");
  a_i_peak_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ch1_valid_i && i_thr_reg < ch1_dbl[23:16]) |=> flags_reg[I_PEAK_FLAG])
    else $error("current peak flag not set");
  a_v_peak_grow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ch2_valid_i && ch2_dbl > v_peak_reg) |=> (v_peak_reg == $past(ch2_dbl)))
    else $error("voltage record missed a larger sample");
  a_i_peak_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_end && cur_reg.addr == I_PEAK_RC_ADDR && !ch1_valid_i) |=> (i_peak_reg == 24'h000000))
    else $error("current record not cleared");
  a_event_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rd_end && cur_reg.addr == FLAGS_RC_ADDR) |=> ((flags_reg & $past(set_vec)) == $past(set_vec)))
    else $error("event lost during clearing read");
  a_temp_delay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (t_state_reg == T_ARMED && zx_edge) |-> ##25 (flags_reg[TEMP_FLAG_BIT] && !temp_route_o
    && route_len_reg == 5'(TEMP_DELAY_CYC)))
    else $error("temperature result not on time");
  a_zx_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ch2_valid_i |=> (zero_cross_o == !$past(ch2_sample_i[23])))
    else $error("zero cross level wrong");

endmodule : pit_monitor

// file: test/pit_host.sv
`timescale 1ns/100ps
module pit_host (
  // Serial port
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  // Request line
  input  wire logic irq_n_i
);
  // ****************************************************************
  // Host side of the serial port
  // ****************************************************************
  logic edge_flag = 1'b0;
  logic irq_hi_cmd = 1'b0;
  logic irq_low_data = 1'b0;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // The host latches falling edges of the request line.
  always @(negedge irq_n_i) edge_flag = 1'b1;

  // The serial clock idles low; after a frame it falls 24 ns after chip select rises.
  task automatic xfer(input logic wr, input logic [5:0] adr, input logic [23:0] wd,
                      output logic [23:0] rd);
    int nb;
    logic [7:0] cmd;
    nb = (adr inside {[6'h09:6'h0c]}) ? 2 : (adr inside {[6'h22:6'h25]}) ? 3 : 1;
    cmd = {wr, 1'b0, adr};
    rd = 24'h0;
    irq_low_data = 1'b0;
    cs_n_o = 1'b0;
    #24;
    for (int i = 7; i >= 0; i--) begin
      sclk_o = 1'b0;
      mosi_o = cmd[i];
      #24 sclk_o = 1'b1;
      #24;
    end
    #48 irq_hi_cmd = irq_n_i;
    for (int i = nb * 8 - 1; i >= 0; i--) begin
      sclk_o = 1'b0;
      mosi_o = wd[i];
      #24 rd = {rd[22:0], miso_i};
      if (irq_n_i !== 1'b1) irq_low_data = 1'b1;
      sclk_o = 1'b1;
      #24;
    end
    #48 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #24 sclk_o = 1'b0;
    #48;
  endtask : xfer

  task automatic service(output logic [23:0] rd);
    edge_flag = 1'b0;
    xfer(1'b0, 6'h0c, 24'h0, rd);
  endtask : service
endmodule : pit_host

// file: test/testbench.sv
`timescale 1ns/100ps
module testbench
  import pit_pkg::*;
;
  // ****************************************************************
  // Stimulus, model state and wiring
  // ****************************************************************
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [23:0] ch1 = 24'h0;
  logic [23:0] ch2 = 24'h0;
  logic        v1 = 1'b0;
  logic        v2 = 1'b0;
  logic [7:0]  tcode = 8'h0;
  logic [31:0] seed = 32'h3ee49e57;
  logic [23:0] rdv;
  logic        mc_prev = 1'b0;
  int n_mismatch = 0;
  int checks_done = 0;
  int m_flags = 0, m_en = 0, m_ipk = 0, m_vpk = 0, m_ti = 255, m_tv = 255;
  int route_cnt = 0, mc_rises = 0, exp_f = 0;
  logic [5:0] radr [8] = '{MODE_ADDR, IRQ_EN_ADDR, FLAGS_ADDR, I_THR_ADDR, V_THR_ADDR,
                           I_PEAK_ADDR, V_PEAK_ADDR, 6'h3f};
  int rexp [8] = '{0, 0, 0, 255, 255, 0, 0, 0};
  wire sclk, cs_n, mosi, miso, miso_oe, irq_n, irq_oe, zx, troute, mclk;
  wire irq_pin = irq_oe ? 1'b0 : 1'b1;
  wire miso_pin = miso_oe ? miso : 1'bz;

  initial forever #4 clk = ~clk;

  pit_monitor i_pit_monitor (.clk_i(clk), .rst_n_i(rst_n), .sclk_i(sclk), .cs_n_i(cs_n),
    .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .ch1_sample_i(ch1), .ch1_valid_i(v1),
    .ch2_sample_i(ch2), .ch2_valid_i(v2), .temp_code_i(tcode), .irq_n_o(irq_n),
    .irq_oe_o(irq_oe), .zero_cross_o(zx), .temp_route_o(troute), .mod_clk_o(mclk));
  pit_host i_pit_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_pin),
    .irq_n_i(irq_pin));

  always @(negedge clk) begin
    if (troute === 1'b1) route_cnt++;
    if (mclk === 1'b1 && mc_prev === 1'b0) mc_rises++;
    mc_prev = mclk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [23:0] sx(input logic [31:0] x);
    return {x[22], x[22], x[21:0]};
  endfunction : sx

  function automatic int mag(input logic [23:0] x);
    int s;
    s = $signed(x);
    return (s < 0) ? -s : s;
  endfunction : mag

  task automatic final_report();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd(input logic [5:0] a, input int exp);
    logic [23:0] d;
    i_pit_host.xfer(1'b0, a, 24'h0, d);
    check(d, 24'(exp));
  endtask : rd

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    logic [23:0] x;
    i_pit_host.xfer(1'b1, a, d, x);
  endtask : wr

  task automatic chk_irq();
    repeat (6) @(negedge clk);
    check({23'h0, irq_pin}, {23'h0, (m_flags & m_en) == 0});
    check({23'h0, irq_n}, {23'h0, (m_flags & m_en) == 0});
  endtask : chk_irq

  // Drives one sample on both channels in the same cycle and updates the model.
  task automatic put(input logic [23:0] a, input logic [23:0] b);
    @(negedge clk);
    ch1 = a;
    ch2 = b;
    v1 = 1'b1;
    v2 = 1'b1;
    @(negedge clk);
    v1 = 1'b0;
    v2 = 1'b0;
    if ((mag(a) * 2) >> 16 > m_ti) m_flags |= 1 << I_PEAK_FLAG;
    if ((mag(b) * 2) >> 16 > m_tv) m_flags |= 1 << V_PEAK_FLAG;
    if (mag(a) > m_ipk) m_ipk = mag(a);
    if (mag(b) * 2 > m_vpk) m_vpk = mag(b) * 2;
    check({23'h0, zx}, {23'h0, ~b[23]});
  endtask : put

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    wr(I_PEAK_ADDR, 24'h123456);
    wr(6'h3f, 24'hff);
    foreach (radr[i]) rd(radr[i], rexp[i]);
    m_ti = 32;
    m_tv = 32;
    wr(I_THR_ADDR, 24'h20);
    wr(V_THR_ADDR, 24'h20);
    put(24'hf00000, 24'h100000);
    rd(FLAGS_ADDR, m_flags);
    put(24'h108000, 24'hef8000);
    rd(FLAGS_ADDR, m_flags);
    chk_irq();
    m_en = 32'h0320;
    wr(IRQ_EN_ADDR, 24'h000320);
    chk_irq();
    repeat (3) begin
      m_ti = int'(rnd() & 63);
      m_tv = int'(rnd() & 63);
      wr(I_THR_ADDR, 24'(m_ti));
      wr(V_THR_ADDR, 24'(m_tv));
      rd(V_THR_ADDR, m_tv);
      repeat (20) put(sx(rnd()), sx(rnd()));
      rd(I_PEAK_ADDR, m_ipk);
      rd(V_PEAK_ADDR, m_vpk);
      rd(I_PEAK_RC_ADDR, m_ipk);
      rd(V_PEAK_RC_ADDR, m_vpk);
      m_ipk = 0;
      m_vpk = 0;
      rd(I_PEAK_ADDR, 0);
      rd(V_PEAK_ADDR, 0);
      chk_irq();
      check({23'h0, i_pit_host.edge_flag}, {23'h0, (m_flags & m_en) != 0});
      i_pit_host.service(rdv);
      check(rdv, 24'(m_flags));
      check({22'h0, i_pit_host.irq_hi_cmd, i_pit_host.irq_low_data}, 24'h2);
      m_flags = 0;
      chk_irq();
    end
    put(24'h3fffff, 24'h000001);
    exp_f = m_flags;
    fork
      i_pit_host.service(rdv);
      begin
        #600;
        put(24'h000001, 24'h3fffff);
      end
    join
    check(rdv, 24'(exp_f));
    check({23'h0, i_pit_host.irq_low_data}, 24'h0);
    m_flags = m_flags & ~exp_f;
    chk_irq();
    i_pit_host.service(rdv);
    check(rdv, 24'(m_flags));
    m_flags = 0;
    @(negedge clk);
    tcode = 8'(rnd());
    put(24'h000001, 24'h000001);
    wr(MODE_ADDR, 24'h000020);
    route_cnt = 0;
    put(24'h000001, 24'hffff00);
    for (int i = 0; i < 200 && !(route_cnt > 0 && troute === 1'b0); i++) @(negedge clk);
    if (route_cnt == 0 || troute !== 1'b0) begin
      n_mismatch++;
      final_report();
    end
    check(24'(route_cnt), 24'd24);
    m_flags |= 1 << TEMP_FLAG_BIT;
    chk_irq();
    rd(TEMP_ADDR, tcode);
    rd(MODE_ADDR, 0);
    i_pit_host.service(rdv);
    check(rdv, 24'(m_flags));
    @(negedge clk);
    #1 mc_rises = 0;
    repeat (16) @(negedge clk);
    #1 check(24'(mc_rises), 24'd4);
    final_report();
  end

  initial begin
    #400000;
    n_mismatch++;
    final_report();
  end
endmodule : testbench
